// ===== bppg_gate.sv
/*
 * blade power permission gate: holds the permission bits and preset throttle
 * level, validates every power request source, forces power off on faults.
 * assumes request inputs are one-cycle pulses synchronous to i_clk_sys and
 * that source identity of a message is decided upstream.
 */
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - no main power before manager grants permission
// - permission kept only in volatile flops
// - non-manager permission writes are blocked
// - non-manager power-off needs local control and permit
// - without permission every power command is ignored
// - button needs local bit 0 and permit bit 1
// - notice manager only on actual setting change
// - remote wake gated like the button plus wake enable bit 2
// - reset gives power off, all permissions disabled
// - manager power message needs only permission
// - non-manager power-on needs local control and permit
// - chipset sleep signal needs local control and permit
// - redundancy loss with power on and permit bit 1 set throttles to preset
// - throttle held until manager un-throttles or changes
// - critical temperature forces main power off
// - voltage sensor fault forces main power off
// - all processors in error forces power off
// - standby return always starts powered off
// - granted permission allows gated power-on
module bppg_gate (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_wr_from_manager,
    output logic [31:0] o_rdata,
    // power requests
    input wire logic i_button_press,
    input wire logic i_remote_wake_packet,
    input wire logic i_sleep_enter,
    input wire logic i_sleep_exit,
    input wire logic i_msg_valid,
    input wire logic i_msg_from_manager,
    input wire logic [1:0] i_msg_code,
    // fault and supply inputs
    input wire logic i_temp_critical,
    input wire logic i_voltage_fault,
    input wire logic [bppg_pkg::NUM_CPUS-1:0] i_processor_internal_error,
    input wire logic i_supply_redundant,
    // outputs
    output logic o_main_power_domain,
    output logic o_throttle_active,
    output logic [7:0] o_throttle_level,
    output logic o_state_change_notice
);
    import bppg_pkg::*;

    logic [2:0] permit_ff;
    logic [7:0] preset_ff;
    logic main_on_ff;
    logic throttle_ff;
    logic notice_ff;
    logic [31:0] rdata_ff;
    logic [7:0] cycle_cnt_ff;
    bppg_state_t state_ff;
    bppg_state_t nxt_state;

    // permission decode
    wire local_ok = permit_ff[BIT_LOCAL_CTRL];
    wire power_ok = permit_ff[BIT_POWER_PERMIT];
    wire wake_ok = permit_ff[BIT_WAKE_ENABLE];
    wire both_ok = local_ok & power_ok;

    // register write decode
    wire wr_permit = i_wr & (i_addr == ADDR_PERMIT) & i_wr_from_manager;
    wire wr_throttle = i_wr & (i_addr == ADDR_THROTTLE) & i_wr_from_manager;
    wire [2:0] new_permit = i_wdata[2:0];
    wire permit_changes = wr_permit & (new_permit != permit_ff);

    // per-source gating
    wire mgr_msg = i_msg_valid & i_msg_from_manager & power_ok;
    wire oth_msg = i_msg_valid & ~i_msg_from_manager & both_ok;
    wire btn_req = i_button_press & both_ok;
    wire wake_req = i_remote_wake_packet & both_ok & wake_ok;
    wire on_req = btn_req & ~main_on_ff
        | wake_req
        | i_sleep_exit & both_ok
        | mgr_msg & (i_msg_code == MSG_ON)
        | oth_msg & (i_msg_code == MSG_ON);
    wire off_req = btn_req & main_on_ff
        | i_sleep_enter & both_ok
        | mgr_msg & (i_msg_code == MSG_OFF)
        | oth_msg & (i_msg_code == MSG_OFF);
    wire cycle_req = mgr_msg & (i_msg_code == MSG_CYCLE);
    // faults act regardless of local control
    wire fault = i_temp_critical
        | i_voltage_fault
        | (&i_processor_internal_error);
    wire cycle_done = (cycle_cnt_ff == 8'(CYCLE_OFF_CYCLES - 1));

    // power state selection; faults first so a same-cycle on loses
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_OFF: begin
                if (!fault && on_req && power_ok) begin
                    nxt_state = ST_ON;
                end
            end
            ST_ON: begin
                if (fault || off_req) begin
                    nxt_state = ST_OFF;
                end else if (cycle_req) begin
                    nxt_state = ST_CYCLE;
                end
            end
            ST_CYCLE: begin
                if (fault || !power_ok) begin
                    nxt_state = ST_OFF;
                end else if (cycle_done) begin
                    nxt_state = ST_ON;
                end
            end
            default: nxt_state = ST_OFF;
        endcase
    end

    // volatile settings: lost on reset, never stored elsewhere
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            permit_ff <= PERMIT_RESET;
            preset_ff <= PRESET_RESET;
        end else begin
            if (wr_permit) begin
                permit_ff <= new_permit;
            end
            if (wr_throttle) begin
                preset_ff <= i_wdata[7:0];
            end
        end
    end

    // power state and cycle timer
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state_ff <= ST_OFF;
            cycle_cnt_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cycle_cnt_ff <= (state_ff == ST_CYCLE) ? cycle_cnt_ff + 8'h01 : 8'h00;
        end
    end

    // main power output from a flop to keep it glitch free
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            main_on_ff <= 1'b0;
        end else begin
            main_on_ff <= (nxt_state == ST_ON);
        end
    end

    // throttle: set on redundancy loss, released only by a manager write
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            throttle_ff <= 1'b0;
        end else if (!i_supply_redundant && main_on_ff && power_ok) begin
            throttle_ff <= 1'b1;
        end else if (wr_throttle) begin
            throttle_ff <= i_wdata[8];
        end
    end

    // one-cycle notice on a real setting change only
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            notice_ff <= 1'b0;
        end else begin
            notice_ff <= permit_changes;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rdata_ff <= 32'h0000_0000;
        end else if (i_rd) begin
            unique case (i_addr)
                ADDR_PERMIT: rdata_ff <= {29'h0, permit_ff};
                ADDR_THROTTLE: rdata_ff <= {23'h0, throttle_ff, preset_ff};
                ADDR_STATUS: rdata_ff <= {30'h0, throttle_ff, main_on_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_main_power_domain = main_on_ff;
    assign o_throttle_active = throttle_ff;
    assign o_throttle_level = throttle_ff ? preset_ff : 8'h00;
    assign o_state_change_notice = notice_ff;

    // assertions

    // checker helper: length of the current run of main power off, saturating
    // so a long idle spell never wraps back into a plausible cycle length
    logic [7:0] off_run_ff;
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            off_run_ff <= 8'h00;
        end else if (main_on_ff) begin
            off_run_ff <= 8'h00;
        end else if (off_run_ff != 8'hff) begin
            off_run_ff <= off_run_ff + 8'h01;
        end
    end

    // power cycle steps: accepted while on, then the return to on
    sequence s_cycle_start;
        state_ff == ST_ON && cycle_req && !fault && !off_req;
    endsequence
    sequence s_cycle_end;
        state_ff == ST_CYCLE ##1 main_on_ff;
    endsequence

    // nothing turns power on while permission is withheld
    a_no_power_unpermitted: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !power_ok && !main_on_ff |=> !main_on_ff)
        else $error("main power rose without permission");

    // foreign writes leave the permission bits alone
    a_foreign_write_blocked: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_wr && !i_wr_from_manager && !wr_permit |=> $stable(permit_ff))
        else $error("non-manager changed permission");

    // a foreign power-off without both bits leaves power on
    a_other_off_gated: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        main_on_ff && i_msg_valid && !i_msg_from_manager && !both_ok && !fault |=> main_on_ff)
        else $error("foreign power-off honoured without both permissions");

    // button alone cannot power on without both bits
    a_button_gated: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !main_on_ff && i_button_press && !both_ok && !mgr_msg && !i_msg_valid
        && !i_remote_wake_packet && !i_sleep_exit |=> !main_on_ff)
        else $error("button powered on without both permissions");

    // notice follows a write exactly when the bits change
    a_notice_on_change: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wr_permit |=> (o_state_change_notice == ($past(new_permit) != $past(permit_ff))))
        else $error("notice mismatch with setting change");

    // critical temperature drops main power
    a_fault_forces_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        fault |=> !main_on_ff)
        else $error("main power stayed on during fault");

    // redundancy loss with power on and permit bit 1 set throttles
    a_throttle_on_loss: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !i_supply_redundant && main_on_ff && power_ok |=> throttle_ff)
        else $error("no throttle after redundancy loss");

    // throttle only ends on a manager write
    a_throttle_holds: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        throttle_ff && !wr_throttle |=> throttle_ff)
        else $error("throttle released without manager");

    // a fault in the same cycle as a power-on wins
    a_fault_beats_on: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !main_on_ff && fault && on_req |=> !main_on_ff)
        else $error("power on won over fault");

    // manager write with bit 8 low ends throttling once supply is back
    a_throttle_release: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        throttle_ff && wr_throttle && !i_wdata[8] && i_supply_redundant |=> !throttle_ff)
        else $error("manager un-throttle not honoured");

    // permission writes from the manager land as written
    a_permit_write_lands: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wr_permit |=> permit_ff == $past(new_permit))
        else $error("manager permission write lost");

    // without a manager write the bits never move
    a_permit_holds: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !wr_permit |=> $stable(permit_ff))
        else $error("permission bits moved without manager write");

    // no notice without a permission write
    a_no_stray_notice: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !wr_permit |=> !o_state_change_notice)
        else $error("notice sent without a setting write");

    // gated button turns power on from off
    a_button_on: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        state_ff == ST_OFF && btn_req && !fault |=> main_on_ff)
        else $error("permitted button press did not power on");

    // gated button turns power off from on
    a_button_toggle_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        state_ff == ST_ON && btn_req |=> !main_on_ff)
        else $error("permitted button press did not power off");

    // foreign power-off honoured with both bits
    a_other_off_honoured: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        state_ff == ST_ON && oth_msg && i_msg_code == MSG_OFF |=> !main_on_ff)
        else $error("permitted foreign power-off ignored");

    // foreign power-on refused without both bits
    a_other_on_gated: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        state_ff == ST_OFF && i_msg_valid && !i_msg_from_manager && !both_ok
        && !i_button_press && !i_remote_wake_packet && !i_sleep_exit |=> !main_on_ff)
        else $error("foreign power-on without both permissions");

    // sleep exit refused without both bits
    a_sleep_gated: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        state_ff == ST_OFF && i_sleep_exit && !both_ok && !i_button_press
        && !i_remote_wake_packet && !i_msg_valid |=> !main_on_ff)
        else $error("sleep exit powered on without both permissions");

    // sleep entry honoured with both bits
    a_sleep_enter_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        state_ff == ST_ON && i_sleep_enter && both_ok |=> !main_on_ff)
        else $error("permitted sleep entry did not power off");

    // remote wake needs its own enable besides both bits
    a_wake_gated: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        state_ff == ST_OFF && i_remote_wake_packet && !wake_ok && !i_button_press
        && !i_sleep_exit && !i_msg_valid |=> !main_on_ff)
        else $error("remote wake powered on while disabled");

    // manager power-on needs only permission
    a_manager_on: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        state_ff == ST_OFF && mgr_msg && i_msg_code == MSG_ON && !fault |=> main_on_ff)
        else $error("manager power-on ignored");

    // manager power-off needs only permission
    a_manager_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        state_ff == ST_ON && mgr_msg && i_msg_code == MSG_OFF |=> !main_on_ff)
        else $error("manager power-off ignored");

    // voltage fault drops main power
    a_voltage_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_voltage_fault |=> !main_on_ff)
        else $error("main power stayed on during voltage fault");

    // every processor in error drops main power
    a_cpu_error_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (&i_processor_internal_error) |=> !main_on_ff)
        else $error("main power stayed on with all processors in error");

    // power cycle first drops power
    a_cycle_goes_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        s_cycle_start |=> !main_on_ff && state_ff == ST_CYCLE)
        else $error("power cycle did not drop main power");

    // power cycle returns after exactly the off time
    a_cycle_off_span: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        s_cycle_end |-> off_run_ff == 8'(CYCLE_OFF_CYCLES))
        else $error("power cycle off time wrong");
endmodule // bppg_gate
`default_nettype wire

// ===== bppg_pkg.sv
/*
 * constants for the blade power permission gate: register map, field
 * positions, reset values, power-cycle timing. assumes nothing of its users.
 */
`default_nettype none
package bppg_pkg;
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] ADDR_PERMIT = 8'h00;
    localparam logic [7:0] ADDR_THROTTLE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    // permission field positions
    localparam int BIT_LOCAL_CTRL = 0;
    localparam int BIT_POWER_PERMIT = 1;
    localparam int BIT_WAKE_ENABLE = 2;
    // reset values
    localparam logic [2:0] PERMIT_RESET = 3'h0;
    localparam logic [7:0] PRESET_RESET = 8'h00;
    // power-cycle off time
    localparam int CYCLE_OFF_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CYCLE_OFF_CYCLES = CYCLE_OFF_NS / CLK_PERIOD_NS;
    // power-state message codes
    localparam logic [1:0] MSG_OFF = 2'h0;
    localparam logic [1:0] MSG_ON = 2'h1;
    localparam logic [1:0] MSG_CYCLE = 2'h2;
    localparam int NUM_CPUS = 2;
    typedef enum logic [1:0] {ST_OFF, ST_ON, ST_CYCLE} bppg_state_t;
endpackage
`default_nettype wire

// ===== bppg_mgr_model.sv
/*
 * chassis manager model for the blade power gate: tallies the state change
 * notices that the blade sends. assumes one-cycle notice pulses on i_clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module bppg_mgr_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // notice from the blade
    input wire logic i_notice,
    // running tally
    output logic [7:0] o_notice_count
);
    // restore policy of the blade is never read; the manager keeps history
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_notice_count <= 8'h00;
        end else if (i_notice) begin
            o_notice_count <= o_notice_count + 8'h01;
        end
    end
endmodule // bppg_mgr_model
`default_nettype wire

// ===== tb_top.sv
/*
 * self-checking bench for the blade power gate: reads are queued and
 * compared by a monitor. assumes the design's register map in the package.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bppg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic wmgr = 1'b0;
    logic mmgr = 1'b0;
    logic [1:0] mcode = 2'h0;
    logic [4:0] req = 5'h00;
    logic temp = 1'b0;
    logic volt = 1'b0;
    logic [1:0] processor_internal_error = 2'h0;
    logic red = 1'b1;
    logic [31:0] rdata;
    logic pwr;
    logic thr;
    logic [7:0] thl;
    logic notice;
    logic [7:0] ncount;
    logic [31:0] lfsr = 32'hca03;
    logic [31:0] exp_q[$];
    int failures = 0;
    int comparisons = 0;

    bppg_gate dut (.i_clk_sys(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .i_wr_from_manager(wmgr), .o_rdata(rdata),
        .i_button_press(req[0]), .i_remote_wake_packet(req[1]), .i_sleep_enter(req[2]),
        .i_sleep_exit(req[3]), .i_msg_valid(req[4]), .i_msg_from_manager(mmgr),
        .i_msg_code(mcode), .i_temp_critical(temp), .i_voltage_fault(volt),
        .i_processor_internal_error(processor_internal_error), .i_supply_redundant(red),
        .o_main_power_domain(pwr), .o_throttle_active(thr), .o_throttle_level(thl),
        .o_state_change_notice(notice));
    bppg_mgr_model mgr (.i_clk_sys(clk), .i_reset(rst), .i_notice(notice),
        .o_notice_count(ncount));

    initial begin
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic m);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wmgr <= m;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wmgr <= 1'b0;
    endtask

    // extra edge so the monitor compares before the next access
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic req_p(input int k, input logic m, input logic [1:0] c);
        @(posedge clk);
        req[k] <= 1'b1;
        mmgr <= m;
        mcode <= c;
        @(posedge clk);
        req <= 5'h00;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d) begin
            chk("rdata", exp_q.pop_front(), rdata);
        end
        rd_d <= rd;
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop;
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_reg(ADDR_PERMIT, 32'h0);
        req_p(0, 1'b0, MSG_OFF);
        req_p(4, 1'b1, MSG_ON);
        req_p(3, 1'b0, MSG_OFF);
        rd_reg(ADDR_STATUS, 32'h0);
        wr_reg(ADDR_PERMIT, 32'h3, 1'b0);
        rd_reg(ADDR_PERMIT, 32'h0);
        wr_reg(ADDR_PERMIT, 32'h2, 1'b1);
        req_p(0, 1'b0, MSG_OFF);
        req_p(1, 1'b0, MSG_OFF);
        req_p(4, 1'b0, MSG_ON);
        rd_reg(ADDR_STATUS, 32'h0);
        req_p(4, 1'b1, MSG_ON);
        rd_reg(ADDR_STATUS, 32'h1);
        req_p(4, 1'b0, MSG_OFF);
        req_p(2, 1'b0, MSG_OFF);
        rd_reg(ADDR_STATUS, 32'h1);
        wr_reg(ADDR_PERMIT, 32'h7, 1'b1);
        wr_reg(ADDR_PERMIT, 32'h7, 1'b1);
        rd_reg(ADDR_PERMIT, 32'h7);
        chk("notices", 32'h2, {24'h0, ncount});
        req_p(4, 1'b0, MSG_OFF);
        rd_reg(ADDR_STATUS, 32'h0);
        req_p(1, 1'b0, MSG_OFF);
        rd_reg(ADDR_STATUS, 32'h1);
        req_p(2, 1'b0, MSG_OFF);
        rd_reg(ADDR_STATUS, 32'h0);
        req_p(3, 1'b0, MSG_OFF);
        rd_reg(ADDR_STATUS, 32'h1);
        req_p(0, 1'b0, MSG_OFF);
        rd_reg(ADDR_STATUS, 32'h0);
        req_p(4, 1'b0, MSG_ON);
        rd_reg(ADDR_STATUS, 32'h1);
        // random preset; bit 8 stays low so the write alone never throttles
        lfsr = nx(lfsr);
        wr_reg(ADDR_THROTTLE, {24'h0, lfsr[7:0]}, 1'b1);
        red <= 1'b0;
        rd_reg(ADDR_STATUS, 32'h3);
        chk("level", {24'h0, lfsr[7:0]}, {24'h0, thl});
        chk("throttle", 32'h1, {31'h0, thr});
        chk("power", 32'h1, {31'h0, pwr});
        red <= 1'b1;
        rd_reg(ADDR_STATUS, 32'h3);
        wr_reg(ADDR_THROTTLE, {24'h0, lfsr[7:0]}, 1'b1);
        rd_reg(ADDR_STATUS, 32'h1);
        processor_internal_error <= 2'h1;
        rd_reg(ADDR_STATUS, 32'h1);
        for (int k = 0; k < 3; k++) begin
            req_p(4, 1'b1, MSG_ON);
            temp <= (k == 0);
            volt <= (k == 1);
            processor_internal_error <= (k == 2) ? 2'h3 : 2'h1;
            rd_reg(ADDR_STATUS, 32'h0);
            temp <= 1'b0;
            volt <= 1'b0;
            processor_internal_error <= 2'h0;
        end
        @(posedge clk);
        temp <= 1'b1;
        req[0] <= 1'b1;
        @(posedge clk);
        req <= 5'h00;
        temp <= 1'b0;
        rd_reg(ADDR_STATUS, 32'h0);
        req_p(4, 1'b1, MSG_ON);
        req_p(4, 1'b1, MSG_CYCLE);
        rd_reg(ADDR_STATUS, 32'h0);
        repeat (CYCLE_OFF_CYCLES) @(posedge clk);
        rd_reg(ADDR_STATUS, 32'h1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_reg(ADDR_PERMIT, 32'h0);
        rd_reg(ADDR_STATUS, 32'h0);
        chk("power", 32'h0, {31'h0, pwr});
        report_and_stop;
    end
endmodule // tb_top
`default_nettype wire
